// ==== hdl/msc_pkg.sv ====
package msc_pkg;
    localparam int FREQ_W = 16;
    localparam int N_TERM = 7;
    localparam int N_PRESET = 16;
    localparam int IDX_W = 4;
    // Clock 10 MHz; settle unit 10 ms
    localparam longint CLK_HZ = 64'h0098_9680;
    localparam int SETTLE_UNIT_MS = 10;
    localparam int UNIT_CYCLES = int'((CLK_HZ * SETTLE_UNIT_MS) / 1000);
    localparam logic [7:0] SETTLE_MAX = 8'hC8;
    // Mode codes
    localparam logic [1:0] MODE_BINARY = 2'h0;
    localparam logic [1:0] MODE_BIT = 2'h1;
    // Frequency source codes
    localparam logic [3:0] SRC_PARAM = 4'h2;
    // Terminal function codes
    localparam logic [7:0] FN_JOG = 8'h06;
    localparam logic [7:0] FN_SEL1 = 8'h02;
    localparam logic [7:0] FN_ONEHOT1 = 8'h20;
    localparam logic [7:0] FN_FORCE_OP = 8'h1F;
    localparam logic [7:0] FN_FORCE_TM = 8'h33;
    localparam logic [FREQ_W-1:0] PRESET_RESET = 16'h0000;

    typedef enum logic [1:0] {
        CMD_PRESET = 2'b00,
        CMD_FORCE_TM = 2'b01,
        CMD_FORCE_OP = 2'b10,
        CMD_JOG = 2'b11
    } cmd_src_t;

    typedef struct packed {
        logic [3:0] sel;
        logic [6:0] onehot;
        logic force_tm;
        logic force_op;
        logic jog;
    } func_lines_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] idx;
    } speed_sel_t;
endpackage

// ==== hdl/msc_preset_mem.sv ====
`timescale 1ns/1ps
module msc_preset_mem (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Write port
    input wire logic i_we,
    input wire logic [msc_pkg::IDX_W-1:0] i_waddr,
    input wire logic [msc_pkg::FREQ_W-1:0] i_wdata,
    // Read port
    input wire logic [msc_pkg::IDX_W-1:0] i_raddr,
    output logic [msc_pkg::FREQ_W-1:0] o_rdata
);
    logic [msc_pkg::FREQ_W-1:0] mem [msc_pkg::N_PRESET];
    logic [msc_pkg::FREQ_W-1:0] next_rdata;

    always_comb begin
        next_rdata = mem[i_raddr];
        if (i_we && i_waddr == i_raddr) begin
            next_rdata = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int k = 0; k < msc_pkg::N_PRESET; k++) begin
                mem[k] <= msc_pkg::PRESET_RESET;
            end
            o_rdata <= msc_pkg::PRESET_RESET;
        end else begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= next_rdata;
        end
    end
endmodule // msc_preset_mem

// ==== hdl/msc_settle_timer.sv ====
`timescale 1ns/1ps
module msc_settle_timer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Control
    input wire logic i_restart,
    input wire logic [7:0] i_units,
    // Status
    output logic o_done
);
    logic [7:0] units_left;
    logic [23:0] tick;
    logic running;
    logic [7:0] next_units_left;
    logic [23:0] next_tick;
    logic next_running;
    logic next_done;

    always_comb begin
        next_units_left = units_left;
        next_tick = tick;
        next_running = running;
        next_done = 1'b0;
        if (i_restart) begin
            next_units_left = i_units;
            next_tick = 24'h00_0000;
            next_running = 1'b1;
        end else if (running) begin
            if (units_left == 8'h00) begin
                next_running = 1'b0;
                next_done = 1'b1;
            end else if (tick == 24'(msc_pkg::UNIT_CYCLES - 1)) begin
                next_tick = 24'h00_0000;
                next_units_left = units_left - 8'h01;
            end else begin
                next_tick = tick + 24'h00_0001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            units_left <= 8'h00;
            tick <= 24'h00_0000;
            running <= 1'b0;
            o_done <= 1'b0;
        end else begin
            units_left <= next_units_left;
            tick <= next_tick;
            running <= next_running;
            o_done <= next_done;
        end
    end
endmodule // msc_settle_timer

// ==== hdl/multi_speed_command_select.sv ====
`timescale 1ns/1ps
module multi_speed_command_select (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // Terminals and their function assignments
    input wire logic [6:0] I_TERMINALS,
    input wire logic [55:0] I_INPUT_FUNC_ASSIGN,
    // Configuration
    input wire logic [1:0] I_PRESET_MODE_SELECT,
    input wire logic [3:0] I_FREQ_SOURCE_SELECT,
    input wire logic [7:0] I_PRESET_SETTLE_TIME,
    input wire logic I_SECOND_MOTOR,
    input wire logic [15:0] I_PRESET_SPEED_0,
    input wire logic [15:0] I_PRESET_SPEED_0_2ND,
    // Other frequency sources
    input wire logic [15:0] I_SOURCE_FREQ,
    input wire logic [15:0] I_FORCED_TERMINAL_FREQ,
    input wire logic [15:0] I_FORCED_OPERATOR_FREQ,
    input wire logic [15:0] I_JOG_FREQ,
    // Preset writes
    input wire logic I_PRESET_WE,
    input wire logic [3:0] I_PRESET_WADDR,
    input wire logic I_OUTPUT_FREQ_WE,
    input wire logic [15:0] I_OUTPUT_FREQ_SETTING,
    // Results
    output logic [15:0] O_FREQ_CMD,
    output logic [3:0] O_SPEED_INDEX,
    output logic [1:0] O_CMD_SOURCE,
    output logic O_SETTLING
);
    // A net, so each generated line may drive its own bit
    wire msc_pkg::func_lines_t lines;
    msc_pkg::speed_sel_t raw_sel;
    logic [3:0] sel_prev;
    logic [3:0] speed;
    logic [3:0] next_speed;
    logic settling;
    logic next_settling;
    logic sel_edge;
    logic timer_done;
    logic mem_we;
    logic [3:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [15:0] preset_rd;
    logic [15:0] next_freq;
    logic [1:0] next_src;
    logic [3:0] bin_idx;

    // Terminal whose assigned code matches fn is on
    function automatic logic func_active(input logic [6:0] term, input logic [55:0] assign_codes,
                                         input logic [7:0] fn);
        logic hit;
        hit = 1'b0;
        for (int t = 0; t < msc_pkg::N_TERM; t++) begin
            if (assign_codes[t*8 +: 8] == fn && term[t]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Unassigned functions never match, so they read as off
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sel
            assign lines.sel[gi] = func_active(I_TERMINALS, I_INPUT_FUNC_ASSIGN,
                8'(msc_pkg::FN_SEL1 + 8'(gi)));
        end
        for (gi = 0; gi < 7; gi++) begin : g_onehot
            assign lines.onehot[gi] = func_active(I_TERMINALS, I_INPUT_FUNC_ASSIGN,
                8'(msc_pkg::FN_ONEHOT1 + 8'(gi)));
        end
    endgenerate
    assign lines.force_tm = func_active(I_TERMINALS, I_INPUT_FUNC_ASSIGN, msc_pkg::FN_FORCE_TM);
    assign lines.force_op = func_active(I_TERMINALS, I_INPUT_FUNC_ASSIGN, msc_pkg::FN_FORCE_OP);
    assign lines.jog = func_active(I_TERMINALS, I_INPUT_FUNC_ASSIGN, msc_pkg::FN_JOG);

    assign bin_idx = lines.sel;

    // Raw decode of the selected speed
    always_comb begin
        raw_sel.valid = 1'b1;
        raw_sel.idx = 4'h0;
        if (I_PRESET_MODE_SELECT == msc_pkg::MODE_BIT) begin
            for (int b = 6; b >= 0; b--) begin
                if (lines.onehot[b]) begin
                    raw_sel.idx = 4'(b + 1);
                end
            end
        end else if (I_PRESET_MODE_SELECT == msc_pkg::MODE_BINARY) begin
            raw_sel.idx = bin_idx;
        end else begin
            raw_sel.valid = 1'b0;
        end
    end

    assign sel_edge = (I_PRESET_MODE_SELECT == msc_pkg::MODE_BINARY)
                      && (lines.sel != sel_prev);

    msc_settle_timer u_timer (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_restart(sel_edge),
        .i_units((I_PRESET_SETTLE_TIME > msc_pkg::SETTLE_MAX) ? msc_pkg::SETTLE_MAX
                 : I_PRESET_SETTLE_TIME),
        .o_done(timer_done)
    );

    // Confirmed speed
    always_comb begin
        next_speed = speed;
        next_settling = settling;
        if (I_PRESET_MODE_SELECT == msc_pkg::MODE_BINARY) begin
            if (sel_edge) begin
                next_settling = 1'b1;
            end else if (timer_done) begin
                next_speed = sel_prev;
                next_settling = 1'b0;
            end
        end else begin
            next_settling = 1'b0;
            if (raw_sel.valid) begin
                next_speed = raw_sel.idx;
            end
        end
    end

    // Writes of the output frequency go to the active preset
    always_comb begin
        mem_we = I_PRESET_WE | I_OUTPUT_FREQ_WE;
        mem_waddr = I_PRESET_WADDR;
        mem_wdata = I_OUTPUT_FREQ_SETTING;
        if (I_OUTPUT_FREQ_WE) begin
            mem_waddr = speed;
        end
    end

    msc_preset_mem u_mem (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(next_speed),
        .o_rdata(preset_rd)
    );

    // Final command source and value
    always_comb begin
        next_src = msc_pkg::CMD_PRESET;
        next_freq = I_SOURCE_FREQ;
        if (lines.force_tm) begin
            next_src = msc_pkg::CMD_FORCE_TM;
            next_freq = I_FORCED_TERMINAL_FREQ;
        end else if (lines.force_op) begin
            next_src = msc_pkg::CMD_FORCE_OP;
            next_freq = I_FORCED_OPERATOR_FREQ;
        end else if (lines.jog) begin
            next_src = msc_pkg::CMD_JOG;
            next_freq = I_JOG_FREQ;
        end else if (speed != 4'h0) begin
            next_freq = preset_rd;
        end else if (I_FREQ_SOURCE_SELECT == msc_pkg::SRC_PARAM) begin
            next_freq = I_SECOND_MOTOR ? I_PRESET_SPEED_0_2ND : I_PRESET_SPEED_0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sel_prev <= 4'h0;
            speed <= 4'h0;
            settling <= 1'b0;
            O_FREQ_CMD <= 16'h0000;
            O_SPEED_INDEX <= 4'h0;
            O_CMD_SOURCE <= msc_pkg::CMD_PRESET;
            O_SETTLING <= 1'b0;
        end else begin
            sel_prev <= lines.sel;
            speed <= next_speed;
            settling <= next_settling;
            O_FREQ_CMD <= next_freq;
            O_SPEED_INDEX <= speed;
            O_CMD_SOURCE <= next_src;
            O_SETTLING <= next_settling;
        end
    end
endmodule // multi_speed_command_select

// ==== dv/msc_term_drv.sv ====
`timescale 1ns/1ps
// Switch bank: all contacts at once, or one contact per clock
module msc_term_drv (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_slow,
    input wire logic [6:0] i_want,
    output logic [6:0] o_term
);
    logic [6:0] diff;
    assign diff = i_want ^ o_term;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst)
            o_term <= 7'h00;
        else if (!i_slow)
            o_term <= i_want;
        else
            o_term <= o_term ^ (diff & -diff);
    end
endmodule // msc_term_drv

// ==== dv/multi_speed_command_select_asserts.sv ====
`timescale 1ns/1ps
module msc_asserts (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic [1:0] I_PRESET_MODE_SELECT,
    input wire logic [3:0] I_FREQ_SOURCE_SELECT,
    input wire logic [7:0] I_PRESET_SETTLE_TIME,
    input wire logic I_SECOND_MOTOR,
    input wire logic [15:0] I_PRESET_SPEED_0,
    input wire logic [15:0] I_PRESET_SPEED_0_2ND,
    input wire logic [15:0] I_SOURCE_FREQ,
    input wire logic [15:0] I_FORCED_TERMINAL_FREQ,
    input wire logic [15:0] I_FORCED_OPERATOR_FREQ,
    input wire logic [15:0] I_JOG_FREQ,
    input wire logic [15:0] O_FREQ_CMD,
    input wire logic [3:0] O_SPEED_INDEX,
    input wire logic [1:0] O_CMD_SOURCE,
    input wire logic O_SETTLING
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    logic idle;
    assign idle = O_SPEED_INDEX == 4'h0 && O_CMD_SOURCE == 2'h0;
    a_force_term: assert property (
        O_CMD_SOURCE == 2'h1 |-> O_FREQ_CMD == $past(I_FORCED_TERMINAL_FREQ))
        else $error("tm freq");
    a_force_op: assert property (
        O_CMD_SOURCE == 2'h2 |-> O_FREQ_CMD == $past(I_FORCED_OPERATOR_FREQ))
        else $error("op freq");
    a_jog_freq: assert property (
        O_CMD_SOURCE == 2'h3 |-> O_FREQ_CMD == $past(I_JOG_FREQ)) else $error("jog freq");
    a_bit_range: assert property (
        (I_PRESET_MODE_SELECT == 2'h1)[*4] |-> O_SPEED_INDEX < 4'h8) else $error("bit idx");
    a_speed0_src: assert property (
        (idle && I_FREQ_SOURCE_SELECT != 4'h2)[*3] |-> O_FREQ_CMD == I_SOURCE_FREQ)
        else $error("speed0 source");
    a_speed0_par: assert property (
        (idle && I_FREQ_SOURCE_SELECT == 4'h2 && $stable(I_SECOND_MOTOR))[*3]
        |-> O_FREQ_CMD == (I_SECOND_MOTOR ? I_PRESET_SPEED_0_2ND : I_PRESET_SPEED_0))
        else $error("speed0 preset");
    a_settle_hold: assert property (
        O_SETTLING ##1 O_SETTLING |-> $stable(O_SPEED_INDEX)) else $error("settle hold");
    a_settle_end: assert property (
        $rose(O_SETTLING) && I_PRESET_SETTLE_TIME == 8'h00 |-> ##[1:8] !O_SETTLING)
        else $error("settle end");
    c_jog: cover property (O_CMD_SOURCE == 2'h3);
    c_bit7: cover property (I_PRESET_MODE_SELECT == 2'h1 && O_SPEED_INDEX == 4'h7);
    c_settle: cover property ($rose(O_SETTLING));
endmodule // msc_asserts
bind multi_speed_command_select msc_asserts u_chk (.*);

// ==== dv/tb_multi_speed_command_select.sv ====
`timescale 1ns/1ps
module tb_multi_speed_command_select;
    localparam logic [15:0] FQ [3] = '{16'h0D0D, 16'h0E0E, 16'h0F0F};
    logic I_CLK, I_NRST, I_SECOND_MOTOR, I_PRESET_WE, I_OUTPUT_FREQ_WE, O_SETTLING, slow;
    logic [6:0] want, I_TERMINALS;
    logic [55:0] I_INPUT_FUNC_ASSIGN;
    logic [1:0] I_PRESET_MODE_SELECT, O_CMD_SOURCE;
    logic [3:0] I_FREQ_SOURCE_SELECT, I_PRESET_WADDR, O_SPEED_INDEX;
    logic [7:0] I_PRESET_SETTLE_TIME;
    logic [15:0] I_PRESET_SPEED_0, I_PRESET_SPEED_0_2ND, I_SOURCE_FREQ, I_JOG_FREQ;
    logic [15:0] I_FORCED_TERMINAL_FREQ, I_FORCED_OPERATOR_FREQ;
    logic [15:0] I_OUTPUT_FREQ_SETTING, O_FREQ_CMD;
    int error_cnt = 0;
    int num_checks = 0;
    multi_speed_command_select dut (.*);
    msc_term_drv u_sw (.i_clk(I_CLK), .i_nrst(I_NRST), .i_slow(slow), .i_want(want),
        .o_term(I_TERMINALS));
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (e !== g) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // Set the switch pattern, then sample at a falling edge
    task automatic go(logic [6:0] t, int n);
        want <= t;
        repeat (n) @(posedge I_CLK);
        @(negedge I_CLK);
    endtask
    function automatic logic [15:0] pv(int k);
        return 16'h1000 + 16'(k);
    endfunction
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        I_CLK = 1'b0;
        forever #50 I_CLK = ~I_CLK;
    end
    initial begin
        #(3000 * 100);
        error_cnt++;
        print_verdict();
    end
    initial begin
        I_NRST = 1'b0;
        want = 7'h00;
        slow = 1'b0;
        I_INPUT_FUNC_ASSIGN = '0;
        I_PRESET_MODE_SELECT = 2'h0;
        I_FREQ_SOURCE_SELECT = 4'h1;
        I_PRESET_SETTLE_TIME = 8'h00;
        I_SECOND_MOTOR = 1'b0;
        I_PRESET_SPEED_0 = 16'h0A0A;
        I_PRESET_SPEED_0_2ND = 16'h0B0B;
        I_SOURCE_FREQ = 16'h0C0C;
        I_FORCED_TERMINAL_FREQ = FQ[0];
        I_FORCED_OPERATOR_FREQ = FQ[1];
        I_JOG_FREQ = FQ[2];
        I_PRESET_WE = 1'b0;
        I_PRESET_WADDR = 4'h0;
        I_OUTPUT_FREQ_WE = 1'b0;
        I_OUTPUT_FREQ_SETTING = 16'h0000;
        repeat (2) @(posedge I_CLK);
        I_NRST <= 1'b1;
        @(posedge I_CLK);
        for (int k = 1; k < 16; k++) begin
            I_PRESET_WE <= 1'b1;
            I_PRESET_WADDR <= 4'(k);
            I_OUTPUT_FREQ_SETTING <= pv(k);
            @(posedge I_CLK);
        end
        I_PRESET_WE <= 1'b0;
        for (int t = 0; t < 4; t++)
            I_INPUT_FUNC_ASSIGN[8*t +: 8] <= 8'(t + 2);
        for (int n = 1; n < 16; n++) begin
            go(7'(n), 10);
            chk("bin_idx", 16'(n), O_SPEED_INDEX);
            chk("bin_freq", pv(n), O_FREQ_CMD);
        end
        go(7'h00, 10);
        chk("src_freq", 16'h0C0C, O_FREQ_CMD);
        I_FREQ_SOURCE_SELECT <= 4'h2;
        go(7'h00, 5);
        chk("p0_freq", 16'h0A0A, O_FREQ_CMD);
        I_SECOND_MOTOR <= 1'b1;
        go(7'h00, 5);
        chk("p0b_freq", 16'h0B0B, O_FREQ_CMD);
        slow <= 1'b1;
        go(7'h0F, 2);
        chk("mid_idx", 16'h0000, O_SPEED_INDEX);
        chk("settling", 16'h0001, O_SETTLING);
        go(7'h0F, 12);
        chk("end_idx", 16'h000F, O_SPEED_INDEX);
        slow <= 1'b0;
        for (int t = 0; t < 7; t++)
            I_INPUT_FUNC_ASSIGN[8*t +: 8] <= 8'h20 + 8'(t);
        I_PRESET_MODE_SELECT <= 2'h1;
        for (int n = 1; n < 8; n++) begin
            go(7'h7F << (n - 1), 6);
            chk("bit_idx", 16'(n), O_SPEED_INDEX);
            chk("bit_freq", pv(n), O_FREQ_CMD);
        end
        go(7'h00, 6);
        chk("bit_off", 16'h0000, O_SPEED_INDEX);
        I_INPUT_FUNC_ASSIGN[7:0] <= 8'h00;
        go(7'h03, 6);
        chk("unassigned", 16'h0002, O_SPEED_INDEX);
        I_OUTPUT_FREQ_SETTING <= 16'h2222;
        I_OUTPUT_FREQ_WE <= 1'b1;
        @(posedge I_CLK);
        I_OUTPUT_FREQ_WE <= 1'b0;
        go(7'h03, 4);
        chk("write_cur", 16'h2222, O_FREQ_CMD);
        I_INPUT_FUNC_ASSIGN[55:32] <= {8'h33, 8'h1F, 8'h06};
        for (int k = 0; k < 3; k++) begin
            go(7'h70 >> k, 6);
            chk("cmd_src", 16'(k + 1), O_CMD_SOURCE);
            chk("cmd_freq", FQ[k], O_FREQ_CMD);
        end
        // Reserved mode code keeps the confirmed speed
        I_PRESET_MODE_SELECT <= 2'h2;
        go(7'h02, 6);
        chk("mode_hold", 16'h0003, O_SPEED_INDEX);
        chk("mode_hold_freq", pv(3), O_FREQ_CMD);
        print_verdict();
    end
endmodule // tb_multi_speed_command_select
